// ---- dv/host_ctrl_model.sv ----
// Host side model: drives the enable pin and reads the pulled-up fault line
`timescale 1ns/1ps
module host_ctrl_model #(
  parameter bit EN_ACTIVE_HIGH = 1'b1  // Polarity the host is wired for
) (
  input  wire logic want_on_i,   // Host wants the load on
  input  wire logic fault_n_i,   // Device fault data value
  input  wire logic fault_oe_i,  // Device pull-down enable
  output logic      enable_o,    // Enable pin level
  output logic      fault_o      // Fault seen on the line
);
  logic line;
  // Host must match the polarity the device was built for
  assign enable_o = want_on_i ? EN_ACTIVE_HIGH : ~EN_ACTIVE_HIGH;
  // Pull-up wins unless the device sinks the line; wire-OR would AND here
  assign line     = fault_oe_i ? fault_n_i : 1'b1;
  assign fault_o  = ~line;
endmodule : host_ctrl_model

// ---- dv/power_switch_protection_sequencer_tb.sv ----
// Scenario testbench for the power switch protection sequencer
`timescale 1ns/1ps
module power_switch_protection_sequencer_tb;
  // ----------------------------------------------------------------
  // Stimulus, two variants side by side
  // ----------------------------------------------------------------
  localparam int unsigned TD  = 20;  // Short tick keeps the run brief
  localparam int unsigned RSD = 1;   // One cycle per ramp step
  logic sys_clk_i = 1'b0;
  logic rst_n_i   = 1'b0;
  logic want_on   = 1'b0;
  logic lockout   = 1'b0;
  logic sag       = 1'b0;
  logic overcur   = 1'b0;
  logic overtemp  = 1'b0;
  logic en_a, en_b, flt_a, flt_b, fn_a, fn_b, oe_a, oe_b;
  pwr_seq_pkg::switch_drive_t drv_a, drv_b;
  int   error_cnt    = 0;
  int   total_checks = 0;
  always #25 sys_clk_i = ~sys_clk_i;
  power_switch_protection_sequencer #(.TICK_DIV(TD), .RAMP_STEP_DIV(RSD)) u_dut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .enable_i(en_a), .lockout_i(lockout),
    .sag_i(sag), .overcur_i(overcur), .overtemp_i(overtemp), .drive_o(drv_a),
    .fault_n_o(fn_a), .fault_oe_o(oe_a));
  power_switch_protection_sequencer #(.EN_ACTIVE_HIGH(1'b0), .SURGE_VARIANT(1'b1),
    .TICK_DIV(TD), .RAMP_STEP_DIV(RSD)) u_dut_surge (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .enable_i(en_b), .lockout_i(lockout),
    .sag_i(sag), .overcur_i(overcur), .overtemp_i(overtemp), .drive_o(drv_b),
    .fault_n_o(fn_b), .fault_oe_o(oe_b));
  host_ctrl_model #(.EN_ACTIVE_HIGH(1'b1)) u_host_a (.want_on_i(want_on),
    .fault_n_i(fn_a), .fault_oe_i(oe_a), .enable_o(en_a), .fault_o(flt_a));
  host_ctrl_model #(.EN_ACTIVE_HIGH(1'b0)) u_host_b (.want_on_i(want_on),
    .fault_n_i(fn_b), .fault_oe_i(oe_b), .enable_o(en_b), .fault_o(flt_b));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : cyc
  task automatic chk(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask : chk
  task automatic close_out();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Enable while locked out, then release; surge limit only in its window
  task automatic t_lockout();
    @(posedge sys_clk_i) lockout <= 1'b1;
    @(posedge sys_clk_i) want_on <= 1'b1;
    cyc(40 * TD);
    chk("on_a", 1'b0, drv_a.switch_on);
    chk("on_b", 1'b0, drv_b.switch_on);
    @(posedge sys_clk_i) lockout <= 1'b0;
    cyc(6);
    chk("on_a", 1'b1, drv_a.switch_on);
    chk("on_b", 1'b1, drv_b.switch_on);
    chk("surge_a", 1'b0, drv_a.surge_limit);
    chk("surge_b", 1'b1, drv_b.surge_limit);
    cyc(300);
    chk("gate_full", 1'b1, drv_a.gate_level === pwr_seq_pkg::RAMP_FULL);
    cyc(130 * TD);
    chk("surge_b", 1'b0, drv_b.surge_limit);
  endtask : t_lockout
  // Short sag, long sag with retries, sag while disabled
  task automatic t_sag();
    @(posedge sys_clk_i) sag <= 1'b1;
    cyc(28 * TD);
    @(posedge sys_clk_i) sag <= 1'b0;
    cyc(10 * TD);
    chk("on_a", 1'b1, drv_a.switch_on);
    @(posedge sys_clk_i) sag <= 1'b1;
    cyc(34 * TD);
    chk("on_a", 1'b0, drv_a.switch_on);
    cyc(120 * TD);
    chk("on_a", 1'b0, drv_a.switch_on);
    cyc(10 * TD);
    chk("on_a", 1'b1, drv_a.switch_on);
    cyc(33 * TD);
    chk("on_a", 1'b0, drv_a.switch_on);
    @(posedge sys_clk_i) want_on <= 1'b0;
    cyc(140 * TD);
    @(posedge sys_clk_i) want_on <= 1'b1;
    cyc(20 * TD);
    chk("on_a", 1'b1, drv_a.switch_on);
    @(posedge sys_clk_i) sag <= 1'b0;
    cyc(300);
  endtask : t_sag
  // Interrupted limit event, then a lasting one in both variants
  task automatic t_fault();
    @(posedge sys_clk_i) overcur <= 1'b1;
    cyc(28 * TD);
    @(posedge sys_clk_i) overcur <= 1'b0;
    cyc(TD);
    @(posedge sys_clk_i) overcur <= 1'b1;
    cyc(28 * TD);
    chk("flt_a", 1'b0, flt_a);
    cyc(6 * TD);
    chk("flt_a", 1'b1, flt_a);
    chk("fault_n_a", 1'b0, fn_a);
    chk("flt_b", 1'b0, flt_b);
    cyc(96 * TD);
    chk("flt_b", 1'b1, flt_b);
    @(posedge sys_clk_i) overcur <= 1'b0;
    cyc(28 * TD);
    chk("flt_a", 1'b1, flt_a);
    cyc(6 * TD);
    chk("flt_a", 1'b0, flt_a);
    chk("flt_b", 1'b1, flt_b);
    cyc(96 * TD);
    chk("flt_b", 1'b0, flt_b);
  endtask : t_fault
  // Thermal cycling, a lasting hot fault, then lockout hides the fault
  task automatic t_hot();
    for (int i = 0; i < 2; i++) begin
      @(posedge sys_clk_i) overtemp <= 1'b1;
      cyc(5);
      chk("on_a", 1'b0, drv_a.switch_on);
      @(posedge sys_clk_i) overtemp <= 1'b0;
      cyc(5);
      chk("on_a", 1'b1, drv_a.switch_on);
    end
    @(posedge sys_clk_i) overtemp <= 1'b1;
    cyc(34 * TD);
    chk("flt_a", 1'b1, flt_a);
    @(posedge sys_clk_i) lockout <= 1'b1;
    overtemp <= 1'b0;
    cyc(5);
    chk("flt_a", 1'b0, flt_a);
    chk("on_a", 1'b0, drv_a.switch_on);
  endtask : t_hot
  // Main sequence; reset held for five cycles
  initial begin
    repeat (5) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    t_lockout();
    t_sag();
    t_fault();
    t_hot();
    close_out();
  end
  // Scenarios need about 20000 cycles; three times that means a hang
  initial begin
    repeat (60000) @(posedge sys_clk_i);
    error_cnt++;
    close_out();
  end
endmodule : power_switch_protection_sequencer_tb

// ---- dv/pwr_seq_properties.sv ----
// Port level assertions for the power switch protection sequencer
`timescale 1ns/1ps
module pwr_seq_properties #(
  parameter bit          EN_ACTIVE_HIGH = 1'b1,  // Enable polarity
  parameter bit          SURGE_VARIANT  = 1'b0,  // Surge variant
  parameter int unsigned TICK_DIV       = pwr_seq_pkg::TICK_CYCLES,  // Cycles per tick
  parameter int unsigned RAMP_STEP_DIV  = 16     // Cycles per ramp step
) (
  input wire logic                       sys_clk_i,   // Clock
  input wire logic                       rst_n_i,     // Reset, active low
  input wire logic                       enable_i,    // Enable pin
  input wire logic                       lockout_i,   // Lockout flag
  input wire logic                       sag_i,       // Sag flag
  input wire logic                       overcur_i,   // Limit flag
  input wire logic                       overtemp_i,  // Hot flag
  input wire pwr_seq_pkg::switch_drive_t drive_o,     // Switch drive
  input wire logic                       fault_n_o,   // Fault data
  input wire logic                       fault_oe_o   // Fault pull-down
);
  // ----------------------------------------------------------------
  // Run counters of the raw conditions
  // ----------------------------------------------------------------
  localparam int unsigned BT   = SURGE_VARIANT ? pwr_seq_pkg::SURGE_TICKS
                                               : pwr_seq_pkg::BLANK_TICKS;
  localparam int unsigned BMIN = (BT - 1) * TICK_DIV;
  localparam int unsigned SMIN = (pwr_seq_pkg::SAG_QUAL_TICKS - 1) * TICK_DIV;
  logic        en_act;
  logic        cond;
  int unsigned sag_run;
  int unsigned cond_run;
  int unsigned clr_run;
  assign en_act = (enable_i == EN_ACTIVE_HIGH);
  assign cond   = overtemp_i | (overcur_i & drive_o.switch_on);
  // Raw runs lead the synchronised ones, so the minimums stay safe
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sag_run  <= 0;
      cond_run <= 0;
      clr_run  <= 0;
    end else begin
      sag_run  <= sag_i ? sag_run + 1 : 0;
      cond_run <= cond ? cond_run + 1 : 0;
      clr_run  <= cond ? 0 : clr_run + 1;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence s_en_rise;
    $rose(en_act) ##0 (en_act && !lockout_i && !overtemp_i)[*4];
  endsequence
  sequence s_hot_clear;
    $fell(overtemp_i) ##0 (en_act && !lockout_i && !overtemp_i)[*4];
  endsequence
  property p_lock_off;
    lockout_i[*4] |-> !drive_o.switch_on;
  endproperty
  property p_lock_quiet;
    lockout_i[*4] |-> !fault_oe_o;
  endproperty
  property p_en_on;
    s_en_rise |-> drive_o.switch_on;
  endproperty
  property p_ramp;
    drive_o.switch_on && $past(drive_o.switch_on)
      |-> 8'(drive_o.gate_level - $past(drive_o.gate_level)) <= 8'h01;
  endproperty
  property p_surge;
    $rose(drive_o.switch_on) |-> drive_o.surge_limit == SURGE_VARIANT;
  endproperty
  property p_sag_qual;
    $fell(drive_o.switch_on) && en_act && !lockout_i && !overtemp_i |-> sag_run >= SMIN;
  endproperty
  property p_blank;
    $rose(fault_oe_o) |-> cond_run >= BMIN;
  endproperty
  property p_hold;
    $fell(fault_oe_o) && !lockout_i && !$past(lockout_i, 3) |-> clr_run >= BMIN;
  endproperty
  property p_hot_back;
    s_hot_clear |-> drive_o.switch_on;
  endproperty
  property p_drain;
    fault_oe_o |-> !fault_n_o;
  endproperty
  a_lock_off: assert property (p_lock_off) else $error("switch on in lockout");
  a_lock_quiet: assert property (p_lock_quiet) else $error("fault in lockout");
  a_en_on: assert property (p_en_on) else $error("enable did not switch on");
  a_ramp: assert property (p_ramp) else $error("gate stepped too fast");
  a_surge: assert property (p_surge) else $error("wrong limit at turn on");
  a_sag_qual: assert property (p_sag_qual) else $error("sag trip too early");
  a_blank: assert property (p_blank) else $error("fault before blanking");
  a_hold: assert property (p_hold) else $error("fault released early");
  a_hot_back: assert property (p_hot_back) else $error("no resume when cool");
  a_drain: assert property (p_drain) else $error("fault pin driven high");
endmodule : pwr_seq_properties

bind power_switch_protection_sequencer pwr_seq_properties #(
  .EN_ACTIVE_HIGH(EN_ACTIVE_HIGH),
  .SURGE_VARIANT (SURGE_VARIANT),
  .TICK_DIV      (TICK_DIV),
  .RAMP_STEP_DIV (RAMP_STEP_DIV)
) u_props (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .enable_i(enable_i),
  .lockout_i(lockout_i), .sag_i(sag_i), .overcur_i(overcur_i), .overtemp_i(overtemp_i),
  .drive_o(drive_o), .fault_n_o(fault_n_o), .fault_oe_o(fault_oe_o));

// ---- rtl/power_switch_protection_sequencer.sv ----
// Sequencer for a current limited high-side load switch
`timescale 1ns/1ps
//
// Contract
// - Switch stays off until supply lockout clears.
// - During lockout enable is ignored and fault is not driven.
// - Sag monitor only acts while the switch is enabled.
// - Sag held 32 ms continuously turns the switch off.
// - After a sag shutdown the switch retries after 128 ms.
// - Sag off and retry repeat while sag persists.
// - Asserted enable turns the main switch on.
// - Enable polarity is a build-time parameter.
// - Fault output is active low for current limit or thermal shutdown.
// - Without surge window fault asserts after 32 ms of fault.
// - Without surge window fault holds 32 ms after clearing.
// - Surge variant asserts fault only if over limit after 128 ms window.
// - Surge variant holds fault 128 ms after clearing.
// - Surge window selects the higher limit, then the normal one.
// - Fault pin is open drain and only pulls low.
// - Every turn-on ramps the gate up gradually.
// - Over temperature turns the switch off and asserts fault.
// - Switch resumes automatically when over temperature clears.
// - Thermal cycling repeats without limit.
module power_switch_protection_sequencer #(
  parameter bit          EN_ACTIVE_HIGH = 1'b1,  // Enable polarity
  parameter bit          SURGE_VARIANT  = 1'b0,  // Surge window variant
  parameter int unsigned TICK_DIV       = pwr_seq_pkg::TICK_CYCLES,
  parameter int unsigned RAMP_STEP_DIV  = 16     // Cycles per soft start step
) (
  input  wire logic                        sys_clk_i,     // 20 MHz clock
  input  wire logic                        rst_n_i,       // Async reset, active low
  input  wire logic                        enable_i,      // Host enable pin level
  input  wire logic                        lockout_i,     // Supply lockout flag
  input  wire logic                        sag_i,         // Input sag flag
  input  wire logic                        overcur_i,     // Current limiting flag
  input  wire logic                        overtemp_i,    // Over temperature flag
  output pwr_seq_pkg::switch_drive_t       drive_o,       // Switch drive bundle
  output logic                             fault_n_o,     // Fault pin output value
  output logic                             fault_oe_o     // Fault pin pull-down enable
);

  // ----------------------------------------------------------------------------
  // Synchronise flags and build the time base
  // ----------------------------------------------------------------------------
  localparam int unsigned NF = 5;
  localparam int unsigned TW = 8;
  localparam logic [TW-1:0] SAG_QUAL  = TW'(pwr_seq_pkg::SAG_QUAL_TICKS);
  localparam logic [TW-1:0] SAG_RETRY = TW'(pwr_seq_pkg::SAG_RETRY_TICKS);
  localparam logic [TW-1:0] BLANK_T   =
    SURGE_VARIANT ? TW'(pwr_seq_pkg::SURGE_TICKS) : TW'(pwr_seq_pkg::BLANK_TICKS);
  localparam logic [TW-1:0] SURGE_T   = TW'(pwr_seq_pkg::SURGE_TICKS);
  localparam int unsigned RSW = (RAMP_STEP_DIV > 1) ? $clog2(RAMP_STEP_DIV) : 1;

  logic [NF-1:0]            raw;
  logic [NF-1:0]            syn;
  pwr_seq_pkg::cond_flags_t flags;
  logic                     en_sync;
  logic                     tick;

  assign raw = {enable_i, lockout_i, sag_i, overcur_i, overtemp_i};

  sync_flags #(
    .WIDTH (NF)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .async_i   (raw),
    .sync_o    (syn)
  );

  // Pins and flags all pass two flops before any logic reads them
  assign en_sync = syn[4];
  assign flags   = pwr_seq_pkg::cond_flags_t'(syn[3:0]);

  tick_gen #(
    .DIV (TICK_DIV)
  ) u_tick (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .tick_o    (tick)
  );

  // ----------------------------------------------------------------------------
  // Enable decode
  // ----------------------------------------------------------------------------
  logic       en_req;
  logic [1:0] sync_fill;

  // The flag flops read zero straight after reset, which an active-low enable
  // would take as a request; hold the switch off until real samples arrive
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_fill <= 2'h0;
    end else begin
      sync_fill <= {sync_fill[0], 1'b1};
    end
  end

  // Polarity fixed at build time; host drives the matching level
  assign en_req = sync_fill[1] && (EN_ACTIVE_HIGH ? en_sync : ~en_sync);

  // ----------------------------------------------------------------------------
  // Switch state machine
  // ----------------------------------------------------------------------------
  pwr_seq_pkg::sw_state_t state;
  pwr_seq_pkg::sw_state_t next_state;
  logic [TW-1:0]          sag_cnt;
  logic [TW-1:0]          retry_cnt;
  localparam int unsigned RAMP_W_L = pwr_seq_pkg::RAMP_W;
  logic [RAMP_W_L-1:0]    gate;
  logic                   sag_trip;
  logic                   retry_done;
  logic                   ramp_done;

  assign sag_trip   = (sag_cnt >= SAG_QUAL);
  assign retry_done = tick && (retry_cnt >= SAG_RETRY - 1'b1);
  assign ramp_done  = (gate == pwr_seq_pkg::RAMP_FULL);

  // Lockout and a dropped enable override everything else; over temperature comes next
  always_comb begin
    next_state = state;
    if (flags.lockout || !en_req) begin
      next_state = pwr_seq_pkg::ST_OFF;
    end else if (flags.overtemp) begin
      next_state = pwr_seq_pkg::ST_HOTOFF;
    end else begin
      unique case (state)
        pwr_seq_pkg::ST_OFF: begin
          next_state = pwr_seq_pkg::ST_RAMP;
        end
        pwr_seq_pkg::ST_RAMP: begin
          if (sag_trip) begin
            next_state = pwr_seq_pkg::ST_SAGOFF;
          end else if (ramp_done) begin
            next_state = pwr_seq_pkg::ST_ON;
          end
        end
        pwr_seq_pkg::ST_ON: begin
          if (sag_trip) begin
            next_state = pwr_seq_pkg::ST_SAGOFF;
          end
        end
        pwr_seq_pkg::ST_SAGOFF: begin
          if (retry_done) begin
            next_state = pwr_seq_pkg::ST_RAMP;
          end
        end
        pwr_seq_pkg::ST_HOTOFF: begin
          // Cooled below the restart point: resume, cycling as often as needed
          next_state = pwr_seq_pkg::ST_RAMP;
        end
        default: begin
          next_state = pwr_seq_pkg::ST_OFF;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= pwr_seq_pkg::ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------------------
  // Sag qualification and retry timers
  // ----------------------------------------------------------------------------
  logic sw_enabled;

  assign sw_enabled = (state == pwr_seq_pkg::ST_RAMP) || (state == pwr_seq_pkg::ST_ON);

  // Sag is only counted while the switch is on; any gap restarts the count
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sag_cnt <= '0;
    end else if (!sw_enabled || !flags.sag) begin
      sag_cnt <= '0;
    end else if (tick && !sag_trip) begin
      sag_cnt <= sag_cnt + 1'b1;
    end
  end

  // Off time after a sag trip
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      retry_cnt <= '0;
    end else if (state != pwr_seq_pkg::ST_SAGOFF) begin
      retry_cnt <= '0;
    end else if (tick) begin
      retry_cnt <= retry_cnt + 1'b1;
    end
  end

  // ----------------------------------------------------------------------------
  // Soft start gate ramp
  // ----------------------------------------------------------------------------
  logic [RSW-1:0] step_cnt;

  // Gate drops at once on turn-off and climbs in steps on each turn-on
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gate     <= pwr_seq_pkg::RAMP_RESET;
      step_cnt <= '0;
    end else if (!sw_enabled) begin
      gate     <= pwr_seq_pkg::RAMP_RESET;
      step_cnt <= '0;
    end else if (!ramp_done) begin
      // Wrap explicitly so a step count that is not a power of two still holds
      if (step_cnt == RSW'(RAMP_STEP_DIV - 1)) begin
        step_cnt <= '0;
        gate     <= gate + 1'b1;
      end else begin
        step_cnt <= step_cnt + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Surge window after turn-on
  // ----------------------------------------------------------------------------
  logic [TW-1:0] surge_cnt;
  logic          surge_active;

  // Window starts at each turn-on; the higher limit only exists in that variant
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      surge_cnt <= '0;
    end else if (!sw_enabled) begin
      surge_cnt <= '0;
    end else if (tick && surge_cnt < SURGE_T) begin
      surge_cnt <= surge_cnt + 1'b1;
    end
  end

  assign surge_active = SURGE_VARIANT && sw_enabled && (surge_cnt < SURGE_T);

  // ----------------------------------------------------------------------------
  // Fault blanking and hold
  // ----------------------------------------------------------------------------
  logic          fault_cond;
  logic [TW-1:0] blank_cnt;
  logic [TW-1:0] hold_cnt;
  logic          fault_flag;

  // Thermal shutdown reports as a fault as well as current limiting
  assign fault_cond = flags.overtemp || (flags.overcur && sw_enabled);

  // Blanking: the condition must persist the full delay; a gap clears it
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      blank_cnt <= '0;
    end else if (!fault_cond || flags.lockout) begin
      blank_cnt <= '0;
    end else if (tick && blank_cnt < BLANK_T) begin
      blank_cnt <= blank_cnt + 1'b1;
    end
  end

  // Fault stays raised for the hold delay after the condition clears
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_flag <= 1'b0;
      hold_cnt   <= '0;
    end else if (flags.lockout) begin
      fault_flag <= 1'b0;
      hold_cnt   <= '0;
    end else if (fault_cond && blank_cnt >= BLANK_T) begin
      fault_flag <= 1'b1;
      hold_cnt   <= '0;
    end else if (fault_cond) begin
      hold_cnt   <= '0;  // A returning condition restarts the hold
    end else if (fault_flag && tick) begin
      if (hold_cnt >= BLANK_T - 1'b1) begin
        fault_flag <= 1'b0;
        hold_cnt   <= '0;
      end else begin
        hold_cnt <= hold_cnt + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  // Pin only ever pulls low; the pull-up lives off chip
  assign fault_n_o  = 1'b0;
  assign fault_oe_o = fault_flag;

  // Drive bundle; surge limit falls back to normal when the window ends
  always_comb begin
    drive_o             = '0;
    drive_o.switch_on   = sw_enabled;
    drive_o.surge_limit = surge_active;
    drive_o.gate_level  = gate;
  end

endmodule : power_switch_protection_sequencer

// ---- rtl/sync_flags.sv ----
// Two-stage synchroniser for a group of asynchronous condition flags
`timescale 1ns/1ps
module sync_flags #(
  parameter int unsigned WIDTH = 4
) (
  input  wire logic             sys_clk_i,  // System clock
  input  wire logic             rst_n_i,    // Async reset, active low
  input  wire logic [WIDTH-1:0] async_i,    // Raw flags from outside the domain
  output logic      [WIDTH-1:0] sync_o      // Flags safe to use in the domain
);

  logic [WIDTH-1:0] meta;

  // ----------------------------------------------------------------------------
  // Two flops; only the second stage is read downstream
  // ----------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta   <= '0;
      sync_o <= '0;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end

endmodule : sync_flags

// ---- rtl/tick_gen.sv ----
// Free-running divider that makes a one-cycle time base tick
`timescale 1ns/1ps
module tick_gen #(
  parameter int unsigned DIV = 20000
) (
  input  wire logic sys_clk_i,  // System clock
  input  wire logic rst_n_i,    // Async reset, active low
  output logic      tick_o      // One-cycle pulse every DIV cycles
);

  localparam int unsigned CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt;

  // ----------------------------------------------------------------------------
  // Counter runs regardless of switch state so delays never drift
  // ----------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt    <= '0;
      tick_o <= 1'b0;
    end else begin
      tick_o <= (cnt == LAST);
      cnt    <= (cnt == LAST) ? '0 : cnt + 1'b1;
    end
  end

endmodule : tick_gen

// ---- shared/pwr_seq_pkg.sv ----
// Shared constants and carrier types for the power switch protection sequencer
package pwr_seq_pkg;

  // ----------------------------------------------------------------------------
  // Clock and time base
  // ----------------------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 20_000_000;  // System clock rate
  localparam int unsigned TICK_US        = 1000;        // Time base period in microseconds
  localparam int unsigned TICK_CYCLES    = CLK_HZ / 1_000_000 * TICK_US;  // Cycles per tick

  // ----------------------------------------------------------------------------
  // Delays, in milliseconds and in ticks of the time base
  // ----------------------------------------------------------------------------
  localparam int unsigned SAG_QUAL_MS    = 32;   // Sag must persist this long
  localparam int unsigned SAG_RETRY_MS   = 128;  // Off time before automatic retry
  localparam int unsigned BLANK_MS       = 32;   // Fault blanking, no surge window
  localparam int unsigned SURGE_MS       = 128;  // Surge window and its fault hold
  localparam int unsigned SAG_QUAL_TICKS  = SAG_QUAL_MS * 1000 / TICK_US;
  localparam int unsigned SAG_RETRY_TICKS = SAG_RETRY_MS * 1000 / TICK_US;
  localparam int unsigned BLANK_TICKS     = BLANK_MS * 1000 / TICK_US;
  localparam int unsigned SURGE_TICKS     = SURGE_MS * 1000 / TICK_US;

  // ----------------------------------------------------------------------------
  // Soft start ramp
  // ----------------------------------------------------------------------------
  localparam int unsigned RAMP_W         = 8;            // Gate drive ramp width
  localparam logic [7:0]  RAMP_FULL      = 8'hff;        // Fully on gate level
  localparam logic [7:0]  RAMP_RESET     = 8'h00;        // Gate level after reset

  // ----------------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------------
  // Condition flags from the analog front end, after synchronising
  typedef struct packed {
    logic lockout;    // Supply below lockout level
    logic sag;        // Supply below sag reference
    logic overcur;    // Switch is current limiting
    logic overtemp;   // Die hot (set at hot trip, clear at cool point)
  } cond_flags_t;

  // Switch drive bundle
  typedef struct packed {
    logic       switch_on;   // Main switch commanded on
    logic       surge_limit; // Higher secondary current limit selected
    logic [7:0] gate_level;  // Soft start gate drive level
  } switch_drive_t;

  typedef enum logic [4:0] {
    ST_OFF    = 5'b00001,
    ST_RAMP   = 5'b00010,
    ST_ON     = 5'b00100,
    ST_SAGOFF = 5'b01000,
    ST_HOTOFF = 5'b10000
  } sw_state_t;

endpackage : pwr_seq_pkg
